// File: verilog/fpu_exec.sv
// Float execution unit: multiply, negate, mode set and store family
`timescale 1ns/10ps

module fpu_exec
    import fpu_exec_pkg::*;
#(
    parameter int MAINT_MODE = 0
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core request
    input wire logic start,
    input wire req_t req,
    // Core answer
    output logic done,
    output resp_t resp,
    output logic [15:0] float_status_register
);

    generate
        if (MAINT_MODE < 0 || MAINT_MODE > 1)
        begin : g_bad_param
            $error("MAINT_MODE must be 0 or 1");
        end
    endgenerate

    typedef struct packed {
        logic [15:0] status;
        logic done;
        resp_t resp;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
    } state_t;

    state_t r_reg;
    state_t r_next;

    function automatic op_t decode(input logic [15:0] w);
        op_t o;
        o = OP_NONE;
        if (w == INSTR_SEL_SGL || w == INSTR_SEL_DBL ||
            w == INSTR_SEL_SHORT || w == INSTR_SEL_LONG)
            o = OP_SEL;
        else if (w[15:6] == GRP_NEG)
            o = OP_NEG;
        else if (w[15:6] == GRP_STSTAT)
            o = OP_STSTAT;
        else if (w[15:8] == CLS_MUL)
            o = OP_MUL;
        else if (w[15:8] == CLS_STORE)
            o = OP_STORE;
        else if (w[15:8] == CLS_STPOW)
            o = OP_STPOW;
        else if (w[15:8] == CLS_STINT)
            o = OP_STINT;
        else if (w[15:8] == CLS_STCNV)
            o = OP_STCNV;
        return o;
    endfunction

    function automatic logic is_neg_zero(input logic [63:0] f);
        return f[SIGN_BIT] && (f[EXP_HI:EXP_LO] == 8'h00);
    endfunction

    // Multiply with normalise and round; exponent kept wide for range test
    function automatic arith_t do_mul(input logic [63:0] a,
                                      input logic [63:0] b,
                                      input logic dbl, input logic trunc);
        logic [MANT_W-1:0] ma;
        logic [MANT_W-1:0] mb;
        logic [2*MANT_W-1:0] full;
        logic [PROD_DBL_W-1:0] p;
        logic [56:0] kept;
        logic [56:0] sum;
        logic rb;
        logic signed [10:0] e;
        logic [MANT_W-1:0] m;
        arith_t o;
        ma = {1'b1, a[FRAC_HI:0]};
        mb = {1'b1, b[FRAC_HI:0]};
        if (!dbl)
        begin
            ma[31:0] = 32'h0;
            mb[31:0] = 32'h0;
        end
        full = ma * mb;
        // Single leaves 48 product bits set, double keeps the top 59
        p = full[2*MANT_W-1 -: PROD_DBL_W];
        e = $signed({3'h0, a[EXP_HI:EXP_LO]}) +
            $signed({3'h0, b[EXP_HI:EXP_LO]}) -
            $signed({3'h0, EXP_BIAS});
        if (!p[PROD_DBL_W-1])
        begin
            p = p << 1;
            e = e - 11'sd1;
        end
        kept = dbl ? {1'b0, p[58:3]} : {1'b0, p[58:35], 32'h0};
        rb = dbl ? p[2] : p[34];
        sum = kept;
        if (!trunc && rb)
            sum = kept + (dbl ? 57'h1 : 57'h1_0000_0000);
        if (sum[56])
        begin
            m = sum[56:1];
            e = e + 11'sd1;
        end
        else
            m = sum[55:0];
        // Exponent wraps mod 256, the offset a trapped result must carry
        o.val = {a[SIGN_BIT] ^ b[SIGN_BIT], e[7:0], m[FRAC_HI:0]};
        o.ovf = e > 11'sd255;
        o.unf = e < 11'sd1;
        return o;
    endfunction

    // Double to single narrowing
    function automatic arith_t do_narrow(input logic [63:0] a,
                                         input logic trunc);
        logic [31:0] rnd;
        arith_t o;
        rnd = {1'b0, a[62:32]};
        if (!trunc)
            rnd = rnd + {31'h0, a[31]};
        o.ovf = rnd[31];
        o.unf = 1'b0;
        o.val = o.ovf ? {a[SIGN_BIT], 63'h0} : {a[SIGN_BIT], rnd[30:0], 32'h0};
        return o;
    endfunction

    // Float to integer: chop, range check; ovf marks a range failure
    function automatic arith_t do_int(input logic [63:0] a, input logic dbl,
                                      input logic lng, input logic to_reg);
        logic signed [9:0] k;
        logic [MANT_W-1:0] mant;
        logic [32:0] mag;
        logic [32:0] lim;
        logic [31:0] v;
        arith_t o;
        k = $signed({2'h0, a[EXP_HI:EXP_LO]}) - $signed({2'h0, EXP_BIAS});
        mant = {1'b1, a[FRAC_HI:0]};
        if (!dbl)
            mant[31:0] = 32'h0;
        lim = lng ? INT_LONG_MAX : INT_SHORT_MAX;
        mag = 33'h0;
        o.ovf = 1'b0;
        o.unf = 1'b0;
        if (k > 10'sd32)
            o.ovf = 1'b1;
        else if (k > 10'sd0)
            mag = 33'(mant >> (7'd56 - 7'(k)));
        if (mag > (a[SIGN_BIT] ? lim + 33'h1 : lim))
            o.ovf = 1'b1;
        v = a[SIGN_BIT] ? 32'(-mag) : mag[31:0];
        if (o.ovf)
            v = 32'h0;
        if (lng && to_reg)
            v = {16'h0, v[31:16]};
        else if (!lng)
            v = {16'h0, v[15:0]};
        o.val = {32'h0, v};
        return o;
    endfunction

    op_t op_now;
    arith_t mul_res;
    arith_t nar_res;
    arith_t int_res;

    assign op_now = decode(req.instr);
    assign mul_res = do_mul(req.acc, req.mem, r_reg.status[ST_DBL],
                            r_reg.status[ST_TRUNC]);
    assign nar_res = do_narrow(req.acc, r_reg.status[ST_TRUNC]);
    assign int_res = do_int(req.acc, r_reg.status[ST_DBL],
                            r_reg.status[ST_LONG], req.dst_is_register);

    always_comb
    begin
        logic [15:0] st;
        logic [63:0] val;
        logic [31:0] iv;
        logic lng;
        logic [15:0] ev;
        st = r_reg.status;
        val = 64'h0;
        iv = 32'h0;
        lng = r_reg.status[ST_LONG];
        ev = 16'h0;
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.resp.write = 1'b0;
        r_next.resp.cpu_flags_write = 1'b0;
        r_next.ready = 1'b1;
        // Bus data phase write, then address phase capture
        if (r_reg.wr_pend && r_reg.wr_addr == REG_STATUS)
            st = hwdata[15:0];
        r_next.wr_pend = 1'b0;
        if (hsel && hready && htrans[1])
        begin
            r_next.wr_pend = hwrite;
            r_next.wr_addr = haddr[7:0];
            case (haddr[7:0])
                REG_STATUS: r_next.rdata = {16'h0, r_reg.status};
                REG_INFO: r_next.rdata = {27'h0, r_reg.resp.cause,
                                          r_reg.resp.write, r_reg.done};
                default: r_next.rdata = 32'h0;
            endcase
        end
        if (start)
        begin
            r_next.done = 1'b1;
            r_next.resp.cause = TRAP_NONE;
            case (op_now)
                OP_MUL:
                begin
                    if (st[ST_UNDEF_TRAP] && is_neg_zero(req.mem))
                        r_next.resp.cause = TRAP_UNDEF;
                    else
                    begin
                        val = mul_res.val;
                        if (req.acc[EXP_HI:EXP_LO] == 8'h00 ||
                            req.mem[EXP_HI:EXP_LO] == 8'h00)
                            val = 64'h0;
                        else if (mul_res.ovf)
                        begin
                            if (st[ST_OVF_TRAP])
                                r_next.resp.cause = TRAP_OVF;
                            else
                                val = 64'h0;
                        end
                        else if (mul_res.unf)
                        begin
                            if (st[ST_UNF_TRAP])
                                r_next.resp.cause = TRAP_UNF;
                            else
                                val = 64'h0;
                        end
                        if (!st[ST_DBL])
                            val[31:0] = 32'h0;
                        r_next.resp.write = 1'b1;
                        r_next.resp.data = val;
                        st[3:0] = {val[SIGN_BIT],
                                   val[EXP_HI:EXP_LO] == 8'h00,
                                   mul_res.ovf, 1'b0};
                    end
                end
                OP_NEG:
                begin
                    if (req.mem[EXP_HI:EXP_LO] != 8'h00)
                        val = {~req.mem[SIGN_BIT], req.mem[62:0]};
                    if (!st[ST_DBL])
                        val[31:0] = 32'h0;
                    if (st[ST_UNDEF_TRAP] && is_neg_zero(req.mem))
                        r_next.resp.cause = TRAP_UNDEF;
                    r_next.resp.write = 1'b1;
                    r_next.resp.data = val;
                    st[3:0] = {val[SIGN_BIT],
                               val[EXP_HI:EXP_LO] == 8'h00, 2'b00};
                end
                OP_SEL:
                begin
                    case (req.instr)
                        INSTR_SEL_SGL: st[ST_DBL] = 1'b0;
                        INSTR_SEL_DBL: st[ST_DBL] = 1'b1;
                        INSTR_SEL_SHORT: st[ST_LONG] = 1'b0;
                        INSTR_SEL_LONG: st[ST_LONG] = 1'b1;
                        default: st[ST_LONG] = st[ST_LONG];
                    endcase
                end
                OP_STCNV:
                begin
                    if (req.acc[EXP_HI:EXP_LO] == 8'h00)
                        val = 64'h0;
                    else if (!st[ST_DBL])
                        val = {req.acc[63:32], 32'h0};
                    else if (nar_res.ovf && !st[ST_OVF_TRAP])
                        val = 64'h0;
                    else
                    begin
                        val = nar_res.val;
                        if (nar_res.ovf)
                            r_next.resp.cause = TRAP_OVF;
                    end
                    r_next.resp.write = 1'b1;
                    r_next.resp.data = val;
                    st[3:0] = {req.acc[SIGN_BIT],
                               req.acc[EXP_HI:EXP_LO] == 8'h00,
                               st[ST_DBL] && req.acc[EXP_HI:EXP_LO] != 8'h00
                               && nar_res.ovf, 1'b0};
                end
                OP_STORE:
                begin
                    r_next.resp.write = 1'b1;
                    r_next.resp.data = st[ST_DBL] ? req.acc :
                                       {req.acc[63:32], 32'h0};
                end
                OP_STINT:
                begin
                    iv = int_res.val[31:0];
                    if (int_res.ovf && st[ST_CONV_TRAP])
                        r_next.resp.cause = TRAP_CONV;
                    r_next.resp.write = 1'b1;
                    r_next.resp.data = int_res.val;
                    st[3:0] = {(lng && !req.dst_is_register) ? iv[31] :
                               iv[15],
                               iv == 32'h0, 1'b0, int_res.ovf};
                    r_next.resp.cpu_flags = st[3:0];
                    r_next.resp.cpu_flags_write = 1'b1;
                end
                OP_STPOW:
                begin
                    ev = {8'h00, req.acc[EXP_HI:EXP_LO]} -
                         {8'h00, EXP_BIAS};
                    r_next.resp.write = 1'b1;
                    r_next.resp.data = {48'h0, ev};
                    st[3:0] = {ev[15], ev == 16'h0, 2'b00};
                    r_next.resp.cpu_flags = st[3:0];
                    r_next.resp.cpu_flags_write = 1'b1;
                end
                OP_STSTAT:
                begin
                    val = {48'h0, st};
                    val[ST_HOLE_HI] = 1'b0;
                    val[ST_HOLE_LO] = 1'b0;
                    if (MAINT_MODE == 0)
                        val[ST_MAINT] = 1'b0;
                    r_next.resp.write = 1'b1;
                    r_next.resp.data = val;
                end
                default:
                    r_next.resp.data = r_reg.resp.data;
            endcase
        end
        r_next.status = st;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r_reg <= '0;
            r_reg.status <= STATUS_RESET;
            r_reg.ready <= 1'b1;
            r_reg.resp.cause <= TRAP_NONE;
        end
        else
            r_reg <= r_next;
    end

    assign done = r_reg.done;
    assign resp = r_reg.resp;
    assign float_status_register = r_reg.status;
    assign hreadyout = r_reg.ready;
    assign hresp = 1'b0;
    assign hrdata = r_reg.rdata;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_done_follows_start: assert property (
        start |=> done ##1 (!done || $past(start)))
        else $error("done did not follow start by one cycle");

    chk_mul_zero_power: assert property (
        start && op_now == OP_MUL &&
        (req.acc[62:55] == 8'h00 || req.mem[62:55] == 8'h00) &&
        !(r_reg.status[ST_UNDEF_TRAP] && is_neg_zero(req.mem))
        |=> resp.write && resp.data == 64'h0 && resp.cause == TRAP_NONE)
        else $error("multiply by zero power did not give zero");

    chk_mul_undef_trap: assert property (
        start && op_now == OP_MUL && r_reg.status[ST_UNDEF_TRAP] &&
        is_neg_zero(req.mem)
        |=> !resp.write && resp.cause == TRAP_UNDEF)
        else $error("negative zero multiply did not trap first");

    chk_mode_select: assert property (
        start && req.instr == INSTR_SEL_DBL
        |=> float_status_register[ST_DBL] ##1 1'b1)
        else $error("select double did not set precision bit");

    chk_long_select: assert property (
        start && req.instr == INSTR_SEL_SHORT
        |=> !float_status_register[ST_LONG])
        else $error("select short did not clear long bit");

    chk_store_keeps_flags: assert property (
        start && op_now == OP_STORE
        |=> float_status_register[3:0] == $past(r_reg.status[3:0]) &&
            resp.cause == TRAP_NONE)
        else $error("plain store changed flags or trapped");

    chk_power_store: assert property (
        start && op_now == OP_STPOW
        |=> resp.data[15:0] == 16'($past(req.acc[62:55])) - 16'h0080 &&
            resp.cause == TRAP_NONE && !resp.cpu_flags.c)
        else $error("exponent store value or flags wrong");

    chk_status_holes: assert property (
        start && op_now == OP_STSTAT
        |=> resp.data[13:12] == 2'b00 &&
            resp.data[11:5] == $past(r_reg.status[11:5]))
        else $error("status store bits wrong");

    chk_neg_zero_power: assert property (
        start && op_now == OP_NEG && req.mem[62:55] == 8'h00
        |=> resp.data == 64'h0 && float_status_register[2])
        else $error("negate of zero power did not give zero");

    chk_int_range_fail: assert property (
        start && op_now == OP_STINT
        |=> resp.cpu_flags.c == float_status_register[0] &&
            (!resp.cpu_flags.c || resp.data == 64'h0))
        else $error("range failure did not write zero");

    chk_narrow_no_undef: assert property (
        start && op_now == OP_STCNV
        |=> resp.cause != TRAP_UNDEF && !float_status_register[0])
        else $error("store convert took undefined trap");

endmodule

// File: verilog/fpu_exec_pkg.sv
// Shared constants, types and decode codes for the float execution unit
package fpu_exec_pkg;

    // Float word layout (single uses the upper 32 bits)
    localparam int SIGN_BIT = 63;
    localparam int EXP_HI = 62;
    localparam int EXP_LO = 55;
    localparam int FRAC_HI = 54;
    localparam int MANT_W = 56;
    localparam int PROD_SGL_W = 48;
    localparam int PROD_DBL_W = 59;
    localparam logic [7:0] EXP_BIAS = 8'h80;

    // Float status register bit positions
    localparam int ST_UNDEF_TRAP = 11;
    localparam int ST_UNF_TRAP = 10;
    localparam int ST_OVF_TRAP = 9;
    localparam int ST_CONV_TRAP = 8;
    localparam int ST_DBL = 7;
    localparam int ST_LONG = 6;
    localparam int ST_TRUNC = 5;
    localparam int ST_MAINT = 4;
    localparam int ST_HOLE_HI = 13;
    localparam int ST_HOLE_LO = 12;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // Instruction words and class codes (octal words given in hex)
    localparam logic [15:0] INSTR_SEL_SGL = 16'hF001;
    localparam logic [15:0] INSTR_SEL_DBL = 16'hF009;
    localparam logic [15:0] INSTR_SEL_SHORT = 16'hFE02;
    localparam logic [15:0] INSTR_SEL_LONG = 16'hFE0A;
    localparam logic [7:0] CLS_MUL = 8'hF2;
    localparam logic [7:0] CLS_STORE = 8'hF8;
    localparam logic [7:0] CLS_STPOW = 8'hFA;
    localparam logic [7:0] CLS_STINT = 8'hFB;
    localparam logic [7:0] CLS_STCNV = 8'hFC;
    localparam logic [9:0] GRP_NEG = 10'h3C7;
    localparam logic [9:0] GRP_STSTAT = 10'h3C2;

    // Integer range limits
    localparam logic [32:0] INT_SHORT_MAX = 33'h0_0000_7FFF;
    localparam logic [32:0] INT_LONG_MAX = 33'h0_7FFF_FFFF;

    // Register bus map
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_INFO = 8'h04;

    typedef enum logic [8:0] {
        OP_NONE = 9'h001,
        OP_MUL = 9'h002,
        OP_NEG = 9'h004,
        OP_SEL = 9'h008,
        OP_STCNV = 9'h010,
        OP_STORE = 9'h020,
        OP_STINT = 9'h040,
        OP_STPOW = 9'h080,
        OP_STSTAT = 9'h100
    } op_t;

    typedef enum logic [2:0] {
        TRAP_NONE = 3'h0,
        TRAP_UNDEF = 3'h1,
        TRAP_OVF = 3'h2,
        TRAP_UNF = 3'h3,
        TRAP_CONV = 3'h4
    } trap_cause_t;

    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } flags_t;

    typedef struct packed {
        logic [15:0] instr;
        logic [63:0] acc;
        logic [63:0] mem;
        logic dst_is_register;
    } req_t;

    typedef struct packed {
        logic [63:0] data;
        logic write;
        trap_cause_t cause;
        flags_t cpu_flags;
        logic cpu_flags_write;
    } resp_t;

    typedef struct packed {
        logic [63:0] val;
        logic ovf;
        logic unf;
    } arith_t;

endpackage

// File: verification/core_model.sv
// Core model: issues one float request and collects its answer
`timescale 1ns/10ps
module core_model
    import fpu_exec_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Request
    output logic start,
    output req_t req,
    // Answer
    input wire logic done,
    input wire resp_t resp
);
    resp_t got = '0;
    logic seen = 1'b0;
    initial
    begin
        start = 1'b0;
        req = '0;
    end
    // Operands scrambled after the taking edge so stale values never match
    task automatic op(input logic [15:0] i, input logic [63:0] a, m,
                      input logic r);
        seen = 1'b0;
        start <= 1'b1;
        req <= '{i, a, m, r};
        @(posedge hclk);
        start <= 1'b0;
        req <= ~req;
        for (int k = 0; k < 3 && !seen; k++)
        begin
            @(posedge hclk);
            seen = (done === 1'b1);
            got = resp;
        end
    endtask
endmodule

// File: verification/fpu_exec_test.sv
// Self-checking bench for the float execution unit
`timescale 1ns/10ps
`define CK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
$display("BAD %s exp %0h got %0h", n, e, g); end end
`define G i_core_model.got
module fpu_exec_test;
    import fpu_exec_pkg::*;
    localparam logic [63:0] H = 64'h4000_0000_0000_0000;
    localparam logic [63:0] NZ = 64'h8000_0000_0000_0000;
    localparam logic [63:0] BIG = 64'h7F80_0000_0000_0000;
    localparam logic [15:0] MUL = {CLS_MUL, 8'h00};
    localparam logic [15:0] NEG = {GRP_NEG, 6'h00};
    localparam logic [15:0] SINT = {CLS_STINT, 8'h00};
    localparam logic [15:0] CNV = {CLS_STCNV, 8'h00};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic hreadyout, hresp, start, done;
    logic [31:0] hrdata, q;
    logic [15:0] fsr;
    req_t req;
    resp_t resp;
    int fails = 0;
    int total_checks = 0;
    always #20 hclk = ~hclk;
    fpu_exec #(.MAINT_MODE(0)) i_fpu_exec (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .start(start), .req(req), .done(done), .resp(resp),
        .float_status_register(fsr));
    core_model i_core_model (.hclk(hclk), .start(start), .req(req),
        .done(done), .resp(resp));
    task automatic test_done;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        `CK("hresp", 1'b0, hresp)
    endtask
    task automatic st(input logic [15:0] v);
        bus(1'b1, REG_STATUS, {16'h0, v});
    endtask
    task automatic run(input logic [15:0] i, input logic [63:0] a, m,
                       input logic r);
        i_core_model.op(i, a, m, r);
        `CK("done", 1'b1, i_core_model.seen)
    endtask
    task automatic modes;
        run(INSTR_SEL_DBL, H, H, 1'b0);
        `CK("dbl", 1'b1, fsr[ST_DBL])
        run(INSTR_SEL_SGL, H, H, 1'b0);
        `CK("sgl", 1'b0, fsr[ST_DBL])
        run(INSTR_SEL_LONG, H, H, 1'b0);
        `CK("long", 1'b1, fsr[ST_LONG])
        run(INSTR_SEL_SHORT, H, H, 1'b0);
        `CK("short", 1'b0, fsr[ST_LONG])
    endtask
    task automatic mul;
        st(16'h0000);
        run(MUL, H, H, 1'b0);
        `CK("sq", 32'h3F80_0000, `G.data[63:32])
        run(MUL, 64'h4000_0001_0000_0000, 64'h4060_0000_0000_0000, 1'b0);
        `CK("rnd", 32'h3FE0_0002, `G.data[63:32])
        st(16'h0020);
        run(MUL, 64'h4000_0001_0000_0000, 64'h4060_0000_0000_0000, 1'b0);
        `CK("trn", 32'h3FE0_0001, `G.data[63:32])
        run(MUL, NZ | H, 64'h0040_0000_0000_0000, 1'b0);
        `CK("zero", 64'h0, `G.data)
        `CK("zflg", 4'h4, fsr[3:0])
        run(MUL, BIG, BIG, 1'b0);
        `CK("ovf", 64'h0, `G.data)
        `CK("vflg", 4'h6, fsr[3:0])
        st(16'h0600);
        run(MUL, BIG, BIG, 1'b0);
        `CK("ovft", 32'h3E80_0000, `G.data[63:32])
        `CK("ovfc", TRAP_OVF, `G.cause)
        run(MUL, 64'h0080_0000_0000_0000, 64'h0080_0000_0000_0000, 1'b0);
        `CK("unft", 32'h4080_0000, `G.data[63:32])
        `CK("unfc", TRAP_UNF, `G.cause)
        st(16'h0080);
        run(MUL, 64'h4000_0000_0000_0001, 64'h4060_0000_0000_0000, 1'b0);
        `CK("dmul", 64'h3FE0_0000_0000_0002, `G.data)
        st(16'h0800);
        run(MUL, H, NZ, 1'b0);
        `CK("udw", 1'b0, `G.write)
        `CK("udc", TRAP_UNDEF, `G.cause)
    endtask
    task automatic neg;
        st(16'h0000);
        run(NEG, H, H, 1'b0);
        `CK("neg", NZ | H, `G.data)
        `CK("negate_single_op", 4'h8, fsr[3:0])
        run(NEG, H, 64'h8040_0000_0000_0000, 1'b0);
        `CK("negz", 64'h0, `G.data)
        st(16'h0800);
        run(NEG, H, NZ, 1'b0);
        `CK("nzd", 64'h0, `G.data)
        `CK("nzc", TRAP_UNDEF, `G.cause)
        `CK("nzf", 4'h4, fsr[3:0])
        st(16'h0805);
        run({CLS_STORE, 8'h00}, NZ, H, 1'b0);
        `CK("cpy", NZ, `G.data)
        `CK("cpyf", 4'h5, fsr[3:0])
        `CK("cpyc", TRAP_NONE, `G.cause)
    endtask
    task automatic sint;
        st(16'h0000);
        run(SINT, 64'h40C0_0000_0000_0000, H, 1'b0);
        `CK("chop", 16'h0001, `G.data[15:0])
        run(SINT, 64'hC800_0000_0000_0000, H, 1'b0);
        `CK("min", 16'h8000, `G.data[15:0])
        `CK("minf", 4'h8, `G.cpu_flags)
        st(16'h0100);
        run(SINT, 64'h4800_0000_0000_0000, H, 1'b0);
        `CK("rng", 32'h0, `G.data[31:0])
        `CK("rngf", 4'h5, `G.cpu_flags)
        `CK("rngc", 1'b1, fsr[0])
        `CK("rngt", TRAP_CONV, `G.cause)
        st(16'h0040);
        run(SINT, 64'h4880_0000_0000_0000, H, 1'b1);
        `CK("hi16", 16'h0001, `G.data[15:0])
        run({CLS_STPOW, 8'h00}, 64'h3F80_0000_0000_0000, H, 1'b0);
        `CK("pow", 16'hFFFF, `G.data[15:0])
        `CK("powf", 4'h8, `G.cpu_flags)
        `CK("powfw", 1'b1, `G.cpu_flags_write)
        st(16'hFFFF);
        run({GRP_STSTAT, 6'h00}, H, H, 1'b0);
        `CK("stat", 16'hCFEF, `G.data[15:0])
        bus(1'b0, REG_STATUS, 32'h0);
        `CK("rdst", 32'h0000_FFFF, q)
        bus(1'b0, 8'h08, 32'h0);
        `CK("unmapped", 32'h0, q)
    endtask
    task automatic cnv;
        st(16'h0800);
        run(CNV, 64'h4000_0000_1234_5678, NZ, 1'b0);
        `CK("wide", H, `G.data)
        `CK("wtrap", TRAP_NONE, `G.cause)
        run(CNV, NZ, H, 1'b0);
        `CK("zsrc", 64'h0, `G.data)
        st(16'h0080);
        run(CNV, 64'h4000_0000_8000_0000, H, 1'b0);
        `CK("nrnd", 32'h4000_0001, `G.data[63:32])
        st(16'h00A0);
        run(CNV, 64'h4000_0000_8000_0000, H, 1'b0);
        `CK("ntrn", 32'h4000_0000, `G.data[63:32])
        st(16'h0080);
        run(CNV, '1, H, 1'b0);
        `CK("nov", 64'h0, `G.data)
        `CK("novf", 4'hA, fsr[3:0])
        st(16'h0280);
        run(CNV, '1, H, 1'b0);
        `CK("novt", 32'h8000_0000, `G.data[63:32])
        `CK("novc", TRAP_OVF, `G.cause)
    endtask
    initial
    begin
        #(40 * 3000);
        fails++;
        test_done;
    end
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        modes;
        mul;
        neg;
        sint;
        cnv;
        test_done;
    end
endmodule
